// ### hw/codec_dma_port.sv
// Data-port FIFOs, request generation and word/byte formatting for the codec.
// Assumes an outside DMA controller on the shared bus and byte engines behind.
`timescale 1ns/100ps
module codec_dma_port #(
  parameter int DEPTH = codec_dma_pkg::FIFO_DEPTH_DEF
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire codec_dma_pkg::apb_req_s APB_REQ,
  output codec_dma_pkg::apb_rsp_s APB_RSP,
  input wire logic [31:0] D_IN,
  output logic [31:0] D_OUT,
  output logic D_OE,
  input wire logic [3:0] ACK_N,
  input wire logic SD,
  output logic COMP_IN_REQUEST_N,
  output logic DECOMP_IN_REQUEST_N,
  output logic COMP_OUT_REQUEST_N,
  output logic DECOMP_OUT_REQUEST_N,
  output codec_dma_pkg::byte_s COMP_ENG_IN,
  input wire logic COMP_ENG_IN_TAKE,
  output codec_dma_pkg::byte_s DECOMP_ENG_IN,
  input wire logic DECOMP_ENG_IN_TAKE,
  input wire logic DECOMP_ENG_EOR_SEEN,
  input wire codec_dma_pkg::byte_s COMP_ENG_OUT,
  output logic COMP_ENG_OUT_READY,
  input wire codec_dma_pkg::byte_s DECOMP_ENG_OUT,
  output logic DECOMP_ENG_OUT_READY
);
  import codec_dma_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || DEPTH > 31 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two from 2 to 16 for 5-bit thresholds.");
    end
  endgenerate

  typedef struct packed {
    logic [NCH-1:0][DEPTH-1:0][WORD_W:0] mem;
    logic [NCH-1:0][PW-1:0] wp;
    logic [NCH-1:0][PW-1:0] rp;
    logic [NCH-1:0][CW-1:0] cnt;
    logic [NCH-1:0][CW-1:0] eors;
    logic [NCH-1:0] lo;
    logic [NCH-1:0] hi;
    logic [NCH-1:0] eorp;
    logic [NCH-1:0] req_n;
    logic [NCH-1:0][1:0] hold;
    logic [NCH-1:0] err;
    logic decomp_length_error;
    logic [3:0] ack_n_d;
    logic sd_d;
    logic [31:0] dout;
    logic doe;
    logic [7:0] cfg;
    logic [31:0] thr;
    logic [NCH-1:0] frst;
    logic [31:0] clen;
    logic [31:0] dlen;
    logic [31:0] crem;
    logic [31:0] drem;
    logic [1:0][31:0] ush;
    logic [1:0][2:0] ucnt;
    logic [1:0] uval;
    logic [1:0][31:0] pw;
    logic [1:0][2:0] pn;
    logic [1:0] pend;
    logic [1:0] peor;
    logic [1:0] prdy;
    apb_rsp_s rsp;
  } st_s;

  st_s s;
  st_s n;
  logic [NCH-1:0] stb;
  logic [NCH-1:0] push;
  logic [NCH-1:0] pop;
  logic [NCH-1:0] eor_pop;
  logic [NCH-1:0] clr_err;
  logic [NCH-1:0] set_err;
  logic [NCH-1:0][WORD_W:0] wdat;
  logic clr_decomp_length_error;
  logic set_decomp_length_error;
  logic wide;
  logic eor_request_timing_sel;
  logic [2:0] strobe_condition_sel;
  logic [2:0] bpw;
  logic [31:0] din;
  logic [31:0] eff_c;
  logic [31:0] eff_d;
  logic [31:0] uw;
  logic [CW-1:0] input_empty_threshold;
  logic [CW-1:0] input_full_threshold;
  logic [CW-1:0] output_empty_threshold;
  logic [CW-1:0] output_full_threshold;
  logic [31:0] rd;
  reg_e sel;
  byte_s bin;

  function automatic logic strobe_fn(input logic [2:0] sc, input logic ackn,
                                     input logic ackn_d, input logic sdi, input logic sdi_d);
    case (sc)
      3'h0: strobe_fn = !ackn && !ackn_d && sdi;
      3'h1: strobe_fn = !ackn && !ackn_d && !sdi;
      3'h2: strobe_fn = !ackn && sdi;
      3'h3: strobe_fn = !ackn && !sdi;
      3'h4: strobe_fn = !ackn_d && sdi_d;
      3'h5: strobe_fn = !ackn_d && !sdi_d;
      default: strobe_fn = ackn && !ackn_d;
    endcase
  endfunction

  // Swapping is its own inverse, so one function serves both directions.
  function automatic logic [31:0] order_fn(input logic [31:0] w, input logic wd,
                                           input logic big);
    if (!big) begin
      order_fn = w;
    end else if (wd) begin
      order_fn = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end else begin
      order_fn = {16'h0000, w[7:0], w[15:8]};
    end
  endfunction

  function automatic logic [31:0] rev_bits(input logic [31:0] w);
    logic [31:0] r;
    r = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      for (int i = 0; i < 8; i++) begin
        r[8*b+i] = w[8*b+7-i];
      end
    end
    rev_bits = r;
  endfunction

  function automatic reg_e reg_sel(input logic [7:0] a);
    case (a)
      OFF_CONFIG: reg_sel = REG_CONFIG;
      OFF_THRESH: reg_sel = REG_THRESH;
      OFF_FIFO_RST: reg_sel = REG_FIFO_RST;
      OFF_STATUS: reg_sel = REG_STATUS;
      OFF_COMP_LEN: reg_sel = REG_COMP_LEN;
      OFF_DECOMP_LEN: reg_sel = REG_DECOMP_LEN;
      OFF_LEVELS: reg_sel = REG_LEVELS;
      default: reg_sel = REG_NONE;
    endcase
  endfunction

  always_comb begin
    n = s;
    stb = '0;
    push = '0;
    pop = '0;
    eor_pop = '0;
    clr_err = '0;
    set_err = '0;
    wdat = '0;
    clr_decomp_length_error = 1'b0;
    set_decomp_length_error = 1'b0;
    eff_c = 32'h00000000;
    eff_d = 32'h00000000;
    uw = 32'h00000000;
    rd = 32'h00000000;
    bin = '0;
    wide = s.cfg[CFG_WIDE];
    eor_request_timing_sel = s.cfg[CFG_ERC];
    strobe_condition_sel = s.cfg[CFG_DSC_LSB +: 3];
    bpw = wide ? 3'(BYTES_WIDE) : 3'(BYTES_NARROW);
    din = wide ? D_IN : {16'h0000, D_IN[15:0]};
    input_empty_threshold = CW'(s.thr[THR_IET_LSB +: THR_W]);
    input_full_threshold = CW'(s.thr[THR_IFT_LSB +: THR_W]);
    output_empty_threshold = CW'(s.thr[THR_OET_LSB +: THR_W]);
    output_full_threshold = CW'(s.thr[THR_OFT_LSB +: THR_W]);
    n.ack_n_d = ACK_N;
    n.sd_d = SD;
    // Register bus: one wait state, the write lands on the edge that completes it.
    sel = reg_sel(APB_REQ.paddr);
    n.rsp.pready = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      rd[8*c +: 8] = 8'(s.cnt[c]);
    end
    if (APB_REQ.psel && APB_REQ.penable && !s.rsp.pready) begin
      n.rsp.pready = 1'b1;
      n.rsp.pslverr = (sel == REG_NONE);
      case (sel)
        REG_CONFIG: n.rsp.prdata = {24'h000000, s.cfg};
        REG_THRESH: n.rsp.prdata = s.thr;
        REG_FIFO_RST: n.rsp.prdata = {28'h0000000, s.frst};
        REG_STATUS: n.rsp.prdata = {23'h000000, s.decomp_length_error, s.err, ~s.req_n};
        REG_COMP_LEN: n.rsp.prdata = s.clen;
        REG_DECOMP_LEN: n.rsp.prdata = s.dlen;
        REG_LEVELS: n.rsp.prdata = rd;
        default: n.rsp.prdata = 32'h00000000;
      endcase
    end
    if (APB_REQ.psel && APB_REQ.penable && s.rsp.pready && APB_REQ.pwrite) begin
      case (sel)
        REG_CONFIG: n.cfg = APB_REQ.pwdata[7:0];
        REG_THRESH: n.thr = APB_REQ.pwdata;
        REG_FIFO_RST: n.frst = APB_REQ.pwdata[3:0];
        REG_STATUS: begin
          clr_err = APB_REQ.pwdata[STS_ERR_LSB +: NCH];
          clr_decomp_length_error = APB_REQ.pwdata[STS_DECOMP_LENGTH_ERROR];
        end
        REG_COMP_LEN: n.clen = APB_REQ.pwdata;
        REG_DECOMP_LEN: n.dlen = APB_REQ.pwdata;
        default: n.cfg = s.cfg;
      endcase
    end
    // Bus strobes move words whatever the request pins show.
    for (int c = 0; c < NCH; c++) begin
      stb[c] = strobe_fn(strobe_condition_sel, ACK_N[c], s.ack_n_d[c], SD, s.sd_d);
      if (stb[c] && !s.frst[c]) begin
        if (c < CH_CO) begin
          if (s.cnt[c] == CW'(DEPTH)) begin
            set_err[c] = 1'b1;
          end else begin
            push[c] = 1'b1;
            wdat[c] = {1'b0, din};
          end
        end else begin
          if (s.cnt[c] == '0) begin
            set_err[c] = 1'b1;
          end else begin
            pop[c] = 1'b1;
            eor_pop[c] = s.mem[c][s.rp[c]][WORD_W];
          end
        end
      end
    end
    // Input unpackers: index 0 feeds compression, index 1 decompression.
    for (int u = 0; u < 2; u++) begin
      if (s.ucnt[u] != 3'd0 && (u == CH_CI ? COMP_ENG_IN_TAKE : DECOMP_ENG_IN_TAKE)) begin
        n.ush[u] = s.ush[u] >> 8;
        n.ucnt[u] = s.ucnt[u] - 3'd1;
        if (u == CH_CI) begin
          eff_c = (s.crem == 32'h00000000) ? s.clen : s.crem;
          if (eff_c == 32'h00000001) begin
            n.ucnt[u] = 3'd0;
            n.crem = 32'h00000000;
          end else begin
            n.crem = eff_c - 32'h00000001;
          end
        end
      end
      if (u == CH_DI && DECOMP_ENG_EOR_SEEN) begin
        n.ucnt[u] = 3'd0;
      end
      if (n.ucnt[u] == 3'd0 && s.cnt[u] != '0 && !s.frst[u]) begin
        pop[u] = 1'b1;
        uw = order_fn(s.mem[u][s.rp[u]][31:0], wide,
                      s.cfg[u == CH_CI ? CFG_COMP_BIG : CFG_DECOMP_BYTE_ORDER_SEL]);
        n.ush[u] = (u == CH_CI && s.cfg[CFG_REVERSE]) ? rev_bits(uw) : uw;
        n.ucnt[u] = bpw;
      end
      if (s.frst[u]) begin
        n.ucnt[u] = 3'd0;
      end
      n.uval[u] = (n.ucnt[u] != 3'd0);
    end
    // Output packers: zero bytes past the record end stay zero in the word.
    for (int p = 0; p < 2; p++) begin
      bin = (p == 0) ? COMP_ENG_OUT : DECOMP_ENG_OUT;
      if (s.pend[p] && s.cnt[CH_CO+p] < CW'(DEPTH) && !s.frst[CH_CO+p]) begin
        push[CH_CO+p] = 1'b1;
        wdat[CH_CO+p] = {s.peor[p], order_fn(s.pw[p], wide,
                         s.cfg[p == 0 ? CFG_COMP_BIG : CFG_DECOMP_BYTE_ORDER_SEL])};
        n.pend[p] = 1'b0;
        n.peor[p] = 1'b0;
        n.pw[p] = 32'h00000000;
        n.pn[p] = 3'd0;
      end
      if (bin.valid && s.prdy[p]) begin
        n.pw[p][{s.pn[p][1:0], 3'b000} +: 8] = bin.data;
        n.pn[p] = s.pn[p] + 3'd1;
        if (n.pn[p] == bpw || bin.last) begin
          n.pend[p] = 1'b1;
          n.peor[p] = bin.last;
        end
        if (p == 1) begin
          eff_d = (s.drem == 32'h00000000) ? s.dlen : s.drem;
          n.drem = bin.last ? 32'h00000000 : eff_d - 32'h00000001;
          set_decomp_length_error = ((eff_d == 32'h00000001) != bin.last);
        end
      end
      if (s.frst[CH_CO+p]) begin
        n.pend[p] = 1'b0;
        n.peor[p] = 1'b0;
        n.pw[p] = 32'h00000000;
        n.pn[p] = 3'd0;
      end
      n.prdy[p] = !n.pend[p] && !s.frst[CH_CO+p];
    end
    n.decomp_length_error = (s.decomp_length_error && !clr_decomp_length_error) || set_decomp_length_error;
    // FIFO storage, counts and the two-stage request pipeline.
    for (int c = 0; c < NCH; c++) begin
      if (push[c]) begin
        n.mem[c][s.wp[c]] = wdat[c];
        n.wp[c] = s.wp[c] + PW'(1);
      end
      if (pop[c]) begin
        n.rp[c] = s.rp[c] + PW'(1);
      end
      n.cnt[c] = s.cnt[c] + CW'(push[c]) - CW'(pop[c]);
      n.eors[c] = s.eors[c] + CW'(push[c] && wdat[c][WORD_W])
                  - CW'(pop[c] && s.mem[c][s.rp[c]][WORD_W]);
      n.err[c] = (s.err[c] && !clr_err[c]) || set_err[c];
      if (s.frst[c]) begin
        n.wp[c] = '0;
        n.rp[c] = '0;
        n.cnt[c] = '0;
        n.eors[c] = '0;
        n.err[c] = 1'b0;
      end
      n.lo[c] = s.cnt[c] <= (c < CH_CO ? input_empty_threshold : output_empty_threshold);
      n.hi[c] = s.cnt[c] >= (c < CH_CO ? input_full_threshold : output_full_threshold);
      n.eorp[c] = (s.eors[c] != '0);
      n.hold[c] = (s.hold[c] != 2'd0) ? s.hold[c] - 2'd1 : 2'd0;
      if (s.frst[c]) begin
        n.req_n[c] = 1'b1;
      end else if (s.err[c]) begin
        n.req_n[c] = 1'b1;
      end else if (c < CH_CO) begin
        if (s.lo[c]) begin
          n.req_n[c] = 1'b0;
        end else if (s.hi[c]) begin
          n.req_n[c] = 1'b1;
        end
      end else if (eor_pop[c]) begin
        n.req_n[c] = 1'b1;
        n.hold[c] = 2'(EOR_HOLD_CYCLES);
      end else if (s.hold[c] != 2'd0) begin
        n.req_n[c] = 1'b1;
      end else if (s.eorp[c]) begin
        n.req_n[c] = 1'b0;
      end else if (s.hi[c]) begin
        n.req_n[c] = 1'b0;
      end else if (s.lo[c]) begin
        n.req_n[c] = 1'b1;
      end
    end
    // The bus shows the head word that the next strobe will take.
    n.doe = 1'b0;
    for (int c = CH_CO; c < NCH; c++) begin
      if (!ACK_N[c] || !s.ack_n_d[c]) begin
        n.doe = 1'b1;
        n.dout = n.mem[c][n.rp[c]][31:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      s <= '0;
      s.req_n <= '1;
      s.ack_n_d <= 4'hF;
      s.cfg <= CONFIG_RST;
      s.thr <= THRESH_RST;
      s.clen <= LEN_RST;
      s.dlen <= LEN_RST;
    end else begin
      s <= n;
    end
  end

  assign APB_RSP = s.rsp;
  assign D_OUT = s.dout;
  assign D_OE = s.doe;
  assign COMP_IN_REQUEST_N = s.req_n[CH_CI];
  assign DECOMP_IN_REQUEST_N = s.req_n[CH_DI];
  // The timing bit clear trades a long pin delay for a same-clock drop.
  assign COMP_OUT_REQUEST_N = s.req_n[CH_CO] || (eor_pop[CH_CO] && !eor_request_timing_sel);
  assign DECOMP_OUT_REQUEST_N = s.req_n[CH_DO] || (eor_pop[CH_DO] && !eor_request_timing_sel);
  assign COMP_ENG_IN = '{data: s.ush[0][7:0], valid: s.uval[0], last: 1'b0};
  assign DECOMP_ENG_IN = '{data: s.ush[1][7:0], valid: s.uval[1], last: 1'b0};
  assign COMP_ENG_OUT_READY = s.prdy[0];
  assign DECOMP_ENG_OUT_READY = s.prdy[1];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_eor_held;
    s.eorp[CH_DO] && !s.err[CH_DO] && !s.frst[CH_DO] && s.hold[CH_DO] == 2'd0
      && !eor_pop[CH_DO];
  endsequence
  sequence s_eor_out_erc;
    eor_pop[CH_DO] && s.cfg[CFG_ERC] && !s.frst[CH_DO];
  endsequence

  property p_rst_quiet;
    s.frst[CH_CI] |=> COMP_IN_REQUEST_N;
  endproperty
  property p_ovf_quiet;
    s.err[CH_CI] |=> COMP_IN_REQUEST_N;
  endproperty
  property p_in_low;
    s.lo[CH_CI] && !s.err[CH_CI] && !s.frst[CH_CI] |=> !COMP_IN_REQUEST_N;
  endproperty
  property p_in_high;
    s.hi[CH_CI] && !s.lo[CH_CI] && !s.err[CH_CI] && !s.frst[CH_CI] |=> COMP_IN_REQUEST_N;
  endproperty
  property p_unf_quiet;
    s.err[CH_CO] |=> COMP_OUT_REQUEST_N;
  endproperty
  property p_eor_req;
    s_eor_held |=> !s.req_n[CH_DO];
  endproperty
  property p_erc0_drop;
    eor_pop[CH_CO] && !s.cfg[CFG_ERC] |-> COMP_OUT_REQUEST_N;
  endproperty
  property p_erc1_drop;
    s_eor_out_erc |=> DECOMP_OUT_REQUEST_N [*2];
  endproperty
  property p_in_latency;
    $rose(s.req_n[CH_CI]) && !$past(s.frst[CH_CI]) && !$past(s.err[CH_CI])
      |-> $past(s.cnt[CH_CI], 2) >= input_full_threshold;
  endproperty
  property p_depth;
    s.cnt[CH_CI] <= CW'(DEPTH);
  endproperty
  property p_status;
    $rose(APB_RSP.pready) && $past(APB_REQ.paddr) == OFF_STATUS
      |-> APB_RSP.prdata[3:0] == ~$past(s.req_n);
  endproperty
  property p_pad;
    s.pend[0] && s.peor[0] && wide && s.pn[0] == 3'd1 |-> s.pw[0][31:8] == 24'h000000;
  endproperty
  property p_decomp_length_error;
    DECOMP_ENG_OUT.valid && s.prdy[1] && DECOMP_ENG_OUT.last && s.drem > 32'h00000001
      |=> s.decomp_length_error;
  endproperty

  a_rst_quiet: assert property (p_rst_quiet) else $error("Request active in reset.");
  a_ovf_quiet: assert property (p_ovf_quiet) else $error("Request after overflow.");
  a_in_low: assert property (p_in_low) else $error("Input request missing.");
  a_in_high: assert property (p_in_high) else $error("Input request kept.");
  a_unf_quiet: assert property (p_unf_quiet) else $error("Request after underflow.");
  a_eor_req: assert property (p_eor_req) else $error("No request on queued END_OF_RECORD.");
  a_erc0_drop: assert property (p_erc0_drop) else $error("No same-clock drop.");
  a_erc1_drop: assert property (p_erc1_drop) else $error("No registered drop.");
  a_in_latency: assert property (p_in_latency) else $error("Early request drop.");
  a_depth: assert property (p_depth) else $error("Count above depth.");
  a_status: assert property (p_status) else $error("Status mismatch.");
  a_pad: assert property (p_pad) else $error("Pad bytes not zero.");
  a_decomp_length_error: assert property (p_decomp_length_error) else $error("Length error missed.");
endmodule

// ### hw/codec_dma_pkg.sv
// Constants, register map and carrier types for the codec data-port block.
// Assumes one 100 MHz clock and an APB master with 32-bit data.
package codec_dma_pkg;
  localparam int NCH = 4;
  localparam int CH_CI = 0;
  localparam int CH_DI = 1;
  localparam int CH_CO = 2;
  localparam int CH_DO = 3;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int WORD_W = 32;
  localparam int BYTES_WIDE = 4;
  localparam int BYTES_NARROW = 2;
  localparam int EOR_HOLD_CYCLES = 2;
  localparam int THR_W = 5;
  localparam int CFG_WIDE = 0;
  localparam int CFG_COMP_BIG = 1;
  localparam int CFG_DECOMP_BYTE_ORDER_SEL = 2;
  localparam int CFG_REVERSE = 3;
  localparam int CFG_ERC = 4;
  localparam int CFG_DSC_LSB = 5;
  localparam int THR_IET_LSB = 0;
  localparam int THR_IFT_LSB = 8;
  localparam int THR_OET_LSB = 16;
  localparam int THR_OFT_LSB = 24;
  localparam int STS_ERR_LSB = 4;
  localparam int STS_DECOMP_LENGTH_ERROR = 8;
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_THRESH = 8'h04;
  localparam logic [7:0] OFF_FIFO_RST = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_COMP_LEN = 8'h10;
  localparam logic [7:0] OFF_DECOMP_LEN = 8'h14;
  localparam logic [7:0] OFF_LEVELS = 8'h18;
  localparam logic [7:0] CONFIG_RST = 8'h01;
  localparam logic [31:0] THRESH_RST = 32'h0D0C0403;
  localparam logic [31:0] LEN_RST = 32'h00000004;
  typedef enum logic [2:0] {
    REG_CONFIG, REG_THRESH, REG_FIFO_RST, REG_STATUS, REG_COMP_LEN, REG_DECOMP_LEN,
    REG_LEVELS, REG_NONE
  } reg_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;
  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } byte_s;
endpackage

// ### bench/dma_ctrl_model.sv
// Model of the outside DMA controller on the shared 32-bit data bus.
// Assumes strobe select 4: ack low one cycle, the word moves at the edge after ack returns high.
`timescale 1ns/100ps
module dma_ctrl_model (
  input wire logic CLK,
  input wire logic [31:0] D_OUT,
  output logic [3:0] ACK_N,
  output logic SD,
  output logic [31:0] D_IN
);
  initial begin
    ACK_N = 4'hF;
    SD = 1'b0;
    D_IN = 32'h00000000;
  end
  // Each call finishes its own transfer first, so two channels never see ack together.
  // The request pins are never consulted: software decides when to move a word.
  task automatic xfer(input int ch, input logic [31:0] wr, output logic [31:0] rd);
    @(posedge CLK);
    ACK_N[ch] <= 1'b0;
    SD <= 1'b1;
    D_IN <= wr;
    @(posedge CLK);
    ACK_N <= 4'hF;
    SD <= 1'b0;
    @(posedge CLK);
    rd = D_OUT;
    // Inverted data after the strobe so a late capture cannot pass by luck.
    D_IN <= ~wr;
  endtask
endmodule

// ### bench/codec_dma_request_and_word_format_tb_top.sv
// Self-checking bench for the codec data port: APB tasks, DMA model, engine stubs.
// Assumes the package, the design and the DMA controller model compile first.
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module codec_dma_request_and_word_format_tb_top;
  import codec_dma_pkg::*;
  logic clk, rst_n, comp_take, cor_n, cir_n, last_err, sd;
  logic [3:0] ack_n;
  logic [31:0] d_in, d_out, rd;
  apb_req_s apb_req;
  apb_rsp_s apb_rsp;
  byte_s comp_eng_in, comp_out, dec_in, dec_out;
  logic comp_out_ready, dec_rdy, dir_n, dor_n, d_oe, deor;
  logic [7:0] got[$];
  int fails, checks, cyc;
  logic [31:0] cfg_t[5] = '{32'h81, 32'h83, 32'h89, 32'h80, 32'h82};
  logic [31:0] word_t[5] = '{32'h44332211, 32'h44332211, 32'h80402001, 32'hFFFF2211,
                             32'hEEEE2211};
  logic [31:0] exp_t[5] = '{32'h44332211, 32'h11223344, 32'h01020480, 32'h2211, 32'h1122};
  int nb_t[5] = '{4, 4, 4, 2, 2};
  codec_dma_port #(.DEPTH(16)) u_codec_dma_port (.CLK(clk), .RESET_N(rst_n),
    .APB_REQ(apb_req), .APB_RSP(apb_rsp), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe),
    .ACK_N(ack_n), .SD(sd), .COMP_IN_REQUEST_N(cir_n), .DECOMP_IN_REQUEST_N(dir_n),
    .COMP_OUT_REQUEST_N(cor_n), .DECOMP_OUT_REQUEST_N(dor_n), .COMP_ENG_IN(comp_eng_in),
    .COMP_ENG_IN_TAKE(comp_take), .DECOMP_ENG_IN(dec_in), .DECOMP_ENG_IN_TAKE(1'b0),
    .DECOMP_ENG_EOR_SEEN(deor), .COMP_ENG_OUT(comp_out), .COMP_ENG_OUT_READY(comp_out_ready),
    .DECOMP_ENG_OUT(dec_out), .DECOMP_ENG_OUT_READY(dec_rdy));
  dma_ctrl_model u_dma_ctrl_model (.CLK(clk), .D_OUT(d_out), .ACK_N(ack_n), .SD(sd),
    .D_IN(d_in));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  always @(posedge clk) begin
    if (rst_n && comp_eng_in.valid && comp_take) begin
      got.push_back(comp_eng_in.data);
    end
  end
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    @(posedge clk);
    while (apb_rsp.pready !== 1'b1) @(posedge clk);
    rd = apb_rsp.prdata;
    last_err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd & m, e)
  endtask
  task automatic send_byte(input logic dec, input logic [7:0] b, input logic l);
    @(posedge clk);
    if (dec) begin
      dec_out <= '{data: b, valid: 1'b1, last: l};
    end else begin
      comp_out <= '{data: b, valid: 1'b1, last: l};
    end
    @(posedge clk);
    while ((dec ? dec_rdy : comp_out_ready) !== 1'b1) @(posedge clk);
    comp_out <= '0;
    dec_out <= '0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    apb_req = '0;
    comp_take = 1'b0;
    comp_out = '0;
    dec_out = '0;
    deor = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(OFF_CONFIG, 32'hFF, 32'h01);
    rchk(OFF_THRESH, 32'hFFFFFFFF, THRESH_RST);
    apb(1'b0, 8'h40, 32'h0);
    `CHK(last_err, 1'b1)
    apb(1'b1, OFF_CONFIG, 32'h81);
    tick(5);
    `CHK(cir_n, 1'b0)
    `CHK(dir_n, 1'b0)
    rchk(OFF_STATUS, 32'hF, 32'h3);
    $display("test reset done");
    // The unpacker takes the first word at once, so five words leave four queued.
    for (int i = 0; i < 5; i++) u_dma_ctrl_model.xfer(CH_CI, 32'h10000000 + i, rd);
    tick(1);
    `CHK(cir_n, 1'b0)
    tick(1);
    `CHK(cir_n, 1'b1)
    rchk(OFF_LEVELS, 32'hFF, 32'h04);
    rchk(OFF_STATUS, 32'h1, 32'h0);
    for (int i = 0; i < 13; i++) u_dma_ctrl_model.xfer(CH_CI, 32'h20000000 + i, rd);
    rchk(OFF_LEVELS, 32'hFF, 32'h10);
    rchk(OFF_STATUS, 32'h10, 32'h10);
    comp_take <= 1'b1;
    tick(120);
    rchk(OFF_LEVELS, 32'hFF, 32'h00);
    `CHK(cir_n, 1'b1)
    apb(1'b1, OFF_STATUS, 32'h10);
    tick(5);
    `CHK(cir_n, 1'b0)
    apb(1'b1, OFF_FIFO_RST, 32'h1);
    tick(3);
    `CHK(cir_n, 1'b1)
    apb(1'b1, OFF_FIFO_RST, 32'h0);
    tick(5);
    `CHK(cir_n, 1'b0)
    $display("test input requests done");
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, OFF_CONFIG, cfg_t[k]);
      got.delete();
      u_dma_ctrl_model.xfer(CH_CI, word_t[k], rd);
      tick(20);
      `CHK(got.size(), nb_t[k])
      for (int j = 0; j < nb_t[k]; j++) `CHK(got[j], exp_t[k][8*j +: 8])
    end
    $display("test word format done");
    apb(1'b1, OFF_CONFIG, 32'h81);
    apb(1'b1, OFF_COMP_LEN, 32'h00000006);
    got.delete();
    u_dma_ctrl_model.xfer(CH_CI, 32'h44332211, rd);
    u_dma_ctrl_model.xfer(CH_CI, 32'h88776655, rd);
    tick(20);
    `CHK(got.size(), 6)
    `CHK(got[5], 8'h66)
    u_dma_ctrl_model.xfer(CH_DI, 32'h44332211, rd);
    u_dma_ctrl_model.xfer(CH_DI, 32'h88776655, rd);
    tick(2);
    `CHK(dec_in.data, 8'h11)
    rchk(OFF_LEVELS, 32'hFF00, 32'h0100);
    @(posedge clk);
    deor <= 1'b1;
    @(posedge clk);
    deor <= 1'b0;
    tick(1);
    `CHK(dec_in.data, 8'h55)
    rchk(OFF_LEVELS, 32'hFF00, 32'h0000);
    $display("test record ends done");
    for (int i = 0; i < 52; i++) send_byte(1'b0, 8'(i), 1'b0);
    tick(5);
    `CHK(cor_n, 1'b0)
    u_dma_ctrl_model.xfer(CH_CO, 32'h0, rd);
    `CHK(rd, 32'h03020100)
    tick(5);
    `CHK(cor_n, 1'b1)
    for (int i = 1; i < 13; i++) u_dma_ctrl_model.xfer(CH_CO, 32'h0, rd);
    `CHK(rd, 32'h33323130)
    for (int i = 1; i < 6; i++) send_byte(1'b0, 8'(i), i == 5);
    tick(5);
    `CHK(cor_n, 1'b0)
    u_dma_ctrl_model.xfer(CH_CO, 32'h0, rd);
    `CHK(rd, 32'h04030201)
    u_dma_ctrl_model.xfer(CH_CO, 32'h0, rd);
    #1;
    `CHK(rd, 32'h00000005)
    `CHK(d_oe, 1'b1)
    `CHK(cor_n, 1'b1)
    u_dma_ctrl_model.xfer(CH_CO, 32'h0, rd);
    rchk(OFF_STATUS, 32'h40, 32'h40);
    tick(3);
    `CHK(cor_n, 1'b1)
    $display("test output requests done");
    // Timing bit set: the drop on the last word must come from the register alone.
    apb(1'b1, OFF_CONFIG, 32'h91);
    for (int i = 1; i < 4; i++) send_byte(1'b1, 8'(i), i == 3);
    tick(5);
    `CHK(dor_n, 1'b0)
    rchk(OFF_STATUS, 32'h100, 32'h100);
    u_dma_ctrl_model.xfer(CH_DO, 32'h0, rd);
    #1;
    `CHK(rd, 32'h00030201)
    `CHK(dor_n, 1'b1)
    tick(1);
    `CHK(dor_n, 1'b1)
    $display("test decompression output done");
    final_report();
  end
endmodule
